// ==== core/iaes_top.sv ====
// Auxiliary interrupt flags, error status and APB register access.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "iaes_map.svh"

module iaes_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Secure link pin
  input wire logic secure_link_input,
  // Command engine
  input wire logic cmd_start,
  input wire logic auto_anticollision_command,
  input wire logic authentication_command,
  input wire logic crc_command_active,
  input wire logic crc_all_processed,
  // Mode detector and field detector
  input wire logic rf_reset,
  input wire logic mode_identified,
  input wire logic field_present,
  output logic mode_detector_active,
  // Receiver, FIFO and sensors
  input wire logic rx_start,
  input wire logic active_comm_mode,
  input wire logic host_fifo_write,
  input wire logic rf_exchange_window,
  input wire logic fifo_write_attempt,
  input wire logic fifo_full,
  input wire logic overheat_detect,
  input wire logic overheat_clear,
  input wire logic field_timeout_evt,
  input wire logic collision_evt,
  input wire logic crc_fail_evt,
  input wire logic parity_fail_evt,
  input wire logic sof_error_evt,
  input wire logic byte_length_evt,
  input wire logic auth_byte_count_evt,
  input wire logic miller_short_evt,
  // Status outputs
  output logic summary_error_flag,
  output logic antenna_driver_off
);
  import iaes_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("iaes_top: ADDR_W must be at least 8");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  localparam logic [9:0] AUX_ADDR = {`IAES_IDX_AUX_FLAGS, 2'b00};
  localparam logic [9:0] ERR_ADDR = {`IAES_IDX_ERROR, 2'b00};
  localparam logic [9:0] CFG_ADDR = {`IAES_IDX_CONFIG, 2'b00};

  iaes_state_t s_q;
  iaes_state_t s_d;

  // Configuration fields held in the configuration register.
  logic rx_crc_check_enable;
  logic sync_detect_enable;
  logic initiator_role;
  logic [1:0] rx_framing_field;
  logic [1:0] tx_framing_field;
  logic [1:0] link_speed;
  logic [9:0] addr10;

  assign rx_crc_check_enable = s_q.cfg[0];
  assign sync_detect_enable = s_q.cfg[1];
  assign initiator_role = s_q.cfg[2];
  assign rx_framing_field = s_q.cfg[4:3];
  assign tx_framing_field = s_q.cfg[6:5];
  assign link_speed = {s_q.cfg[7], 1'b0} | {1'b0, 1'b0};
  assign addr10 = {{(10 - 8){1'b0}}, paddr[7:0]};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] aux_set;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic [31:0] rd;
    logic wr_done;
    logic sec_edge;
    logic speed_106;
    logic speed_high;
    logic mapped;
    aux_set = 8'h00;
    err_set = 8'h00;
    err_clr = 8'h00;
    rd = 32'h0000_0000;
    wr_done = 1'b0;
    sec_edge = 1'b0;
    speed_106 = 1'b0;
    speed_high = 1'b0;
    mapped = 1'b0;
    s_d = s_q;

    speed_106 = (link_speed == `IAES_SPEED_106);
    speed_high = (link_speed == `IAES_SPEED_212) ||
                 (link_speed == `IAES_SPEED_424);

    // The first synchroniser stage feeds only the second one.
    s_d.sec_sync = {s_q.sec_sync[1:0], secure_link_input};
    sec_edge = s_q.sec_sync[2] ^ s_q.sec_sync[1];
    s_d.field_prev = field_present;

    // Mode detector.
    case (s_q.md_state)
      IAES_MD_IDLE: begin
        if ((cmd_start && auto_anticollision_command) || rf_reset) begin
          s_d.md_state = IAES_MD_RUN;
        end
      end
      IAES_MD_RUN: begin
        if (mode_identified) begin
          s_d.md_state = IAES_MD_IDLE;
          aux_set[3] = 1'b1;
        end
      end
      default: begin
        s_d.md_state = IAES_MD_IDLE;
      end
    endcase

    // Auxiliary flag events.
    aux_set[4] = aux_set[4] | sec_edge;
    aux_set[2] = crc_command_active && crc_all_processed;
    aux_set[1] = field_present && !s_q.field_prev;
    aux_set[0] = !field_present && s_q.field_prev;

    // Error events.
    err_set[7] = host_fifo_write && (auto_anticollision_command ||
                 authentication_command || rf_exchange_window);
    err_set[6] = overheat_detect;
    err_set[5] = field_timeout_evt && active_comm_mode &&
                 ((rx_framing_field == `IAES_FRAMING_ACTIVE) ||
                  (tx_framing_field == `IAES_FRAMING_ACTIVE));
    err_set[4] = fifo_write_attempt && fifo_full;
    err_set[3] = (collision_evt && speed_106) || speed_high;
    err_set[2] = crc_fail_evt && rx_crc_check_enable;
    err_set[1] = parity_fail_evt && speed_106;
    err_set[0] = (sof_error_evt && speed_106) ||
                 (byte_length_evt && sync_detect_enable &&
                  !speed_106) ||
                 (auto_anticollision_command && initiator_role) ||
                 (auth_byte_count_evt && authentication_command) ||
                 miller_short_evt;

    // Clears; a set in the same cycle always wins.
    if (rx_start) begin
      err_clr = err_clr | `IAES_ERR_RXCLR_MASK;
    end
    if (cmd_start) begin
      err_clr = err_clr | ~`IAES_ERR_KEEP_MASK;
    end
    if (overheat_clear) begin
      err_clr = err_clr | `IAES_ERR_KEEP_MASK;
    end

    // APB decode; a request answers after one wait state.
    if (addr10 == AUX_ADDR) begin
      mapped = 1'b1;
      rd = {24'h00_0000, s_q.aux_flags & `IAES_AUX_WMASK};
    end else if (addr10 == ERR_ADDR) begin
      mapped = 1'b1;
      rd = {24'h00_0000, s_q.err};
    end else if (addr10 == CFG_ADDR) begin
      mapped = 1'b1;
      rd = {24'h00_0000, s_q.cfg};
    end

    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !mapped;
      s_d.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    wr_done = psel && penable && s_q.pready && pwrite && mapped;

    // Software sets or clears flags by bit 7; hardware only ever sets them.
    if (wr_done && (addr10 == AUX_ADDR)) begin
      if (pwdata[`IAES_SET_SEL_BIT]) begin
        aux_set = aux_set | (pwdata[7:0] & `IAES_AUX_WMASK);
      end else begin
        s_d.aux_flags = s_q.aux_flags &
                        ~(pwdata[7:0] & `IAES_AUX_WMASK);
      end
    end
    if (wr_done && (addr10 == CFG_ADDR)) begin
      s_d.cfg = pwdata[7:0];
    end
    // Writes to the error register are ignored.

    s_d.aux_flags = (s_d.aux_flags | aux_set) & `IAES_AUX_WMASK;
    s_d.err = (s_q.err & ~err_clr) | err_set;
    s_d.summary = |s_d.err;
    s_d.antenna_off = s_d.err[6];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.aux_flags <= `IAES_AUX_RESET;
      s_q.err <= `IAES_ERR_RESET;
      s_q.cfg <= `IAES_CFG_RESET;
      s_q.sec_sync <= 3'b000;
      s_q.field_prev <= 1'b0;
      s_q.md_state <= IAES_MD_IDLE;
      s_q.summary <= 1'b0;
      s_q.antenna_off <= 1'b0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign summary_error_flag = s_q.summary;
  assign antenna_driver_off = s_q.antenna_off;
  assign mode_detector_active = (s_q.md_state == IAES_MD_RUN);

endmodule

// ==== common/iaes_map.svh ====
// Register offsets, field positions, reset values and speed codes.
// Operation
// - Flag register write sets marked flags when bit 7 is one, else clears.
// - Secure input edge flag, bit 4, sets on either input edge.
// - Mode detect flag, bit 3, sets when the mode detector identifies mode.
// - Mode detector starts by auto-anticollision or RF reset; stops after detection.
// - Mode detector restarts after RF reset, unless it is running and identifies mode in the same cycle.
// - CRC done flag, bit 2, sets when CRC command finishes all data.
// - Field on flag, bit 1, and field off flag, bit 0, follow field.
// - Host FIFO write in protected commands or RF window sets bit 7.
// - Overheat sets bit 6 and switches the antenna drivers off.
// - Field timeout bit 5 only in active mode with framing 01.
// - Write attempt into a full FIFO sets overflow bit 4.
// - Collision bit 3 sets on collision, clears at rx start, reads one >106k.
// - CRC error bit 2 sets when check enabled and fails; rx start clears.
// - Parity error bit 1 sets on parity fail at 106k; rx start clears.
// - Protocol error bit 0 sets on bad start of frame at 106k.
// - Byte length violation with sync detect above 106k raises protocol error.
// - Initiator bit set during auto-anticollision raises protocol error.
// - Wrong byte count in authentication raises protocol error.
// - Two Miller pulses closer than minimum time raise protocol error.
// - Command start clears all errors but overheat; software cannot set them.
// - Error register is read-only, index 06h, resets to 00h.
// - Summary error flag follows any error bit being one.
`ifndef IAES_MAP_SVH
`define IAES_MAP_SVH

`define IAES_IDX_AUX_FLAGS 8'h05
`define IAES_IDX_ERROR 8'h06
`define IAES_IDX_CONFIG 8'h10
`define IAES_AUX_RESET 8'h00
`define IAES_ERR_RESET 8'h00
`define IAES_CFG_RESET 8'h00
`define IAES_AUX_WMASK 8'h1F
`define IAES_SET_SEL_BIT 7
`define IAES_ERR_KEEP_MASK 8'h40
`define IAES_ERR_RXCLR_MASK 8'h0F
`define IAES_SPEED_106 2'b00
`define IAES_SPEED_212 2'b01
`define IAES_SPEED_424 2'b10
`define IAES_FRAMING_ACTIVE 2'b01

`endif

// ==== common/iaes_pkg.sv ====
// Types for the auxiliary flag and error status block.
package iaes_pkg;

  typedef enum logic [0:0] {
    IAES_MD_IDLE = 1'b0,
    IAES_MD_RUN = 1'b1
  } iaes_md_state_t;

  typedef struct packed {
    logic [7:0] aux_flags;
    logic [7:0] err;
    logic [7:0] cfg;
    logic [2:0] sec_sync;
    logic field_prev;
    iaes_md_state_t md_state;
    logic summary;
    logic antenna_off;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } iaes_state_t;

endpackage

// ==== test/iaes_chk.sv ====
// Port-level assertions for the flag and error status block.
`timescale 1ns/1ps
module iaes_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched inputs
  input wire logic cmd_start,
  input wire logic auto_anticollision_command,
  input wire logic rf_reset,
  input wire logic mode_identified,
  input wire logic rx_start,
  input wire logic overheat_detect,
  input wire logic overheat_clear,
  input wire logic collision_evt,
  // Watched outputs
  input wire logic mode_detector_active,
  input wire logic summary_error_flag,
  input wire logic antenna_driver_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_start;
    cmd_start && auto_anticollision_command;
  endsequence
  sequence s_hit;
    mode_detector_active && mode_identified && !rf_reset && !cmd_start;
  endsequence
  a_err_summary: assert property (collision_evt |=> summary_error_flag)
    else $error("summary flag missed an error");
  a_sum_hold: assert property (summary_error_flag && !cmd_start
    && !rx_start && !overheat_clear |=> summary_error_flag)
    else $error("summary flag dropped without a clear");
  a_heat_off: assert property (overheat_detect |=> antenna_driver_off)
    else $error("antenna drivers stayed on");
  a_heat_keep: assert property (antenna_driver_off && !overheat_clear
    |=> antenna_driver_off)
    else $error("overheat error lost");
  a_heat_clr: assert property (overheat_clear && !overheat_detect
    |=> !antenna_driver_off)
    else $error("overheat error not cleared");
  a_md_start: assert property (s_start ##0 !mode_identified
    |=> mode_detector_active)
    else $error("mode detector did not start");
  a_md_stop: assert property (s_hit |=> !mode_detector_active)
    else $error("mode detector did not stop");
  a_md_rfrst: assert property (rf_reset && !mode_identified
    |=> mode_detector_active)
    else $error("mode detector not restarted");
  a_md_only: assert property (!mode_detector_active && !rf_reset
    && !(cmd_start && auto_anticollision_command) |=> !mode_detector_active)
    else $error("mode detector started by itself");
endmodule
bind iaes_top iaes_chk i_iaes_chk (.*);

// ==== test/iaes_host.sv ====
// Host model issuing APB transfers to the register block.
`timescale 1ns/1ps
module iaes_host (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Flags are cleared by writes issued here or by reset.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep a value the slave could reuse.
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ==== test/irq_and_error_status_flags_test.sv ====
// Self-checking bench for the flag and error status block.
`timescale 1ns/1ps
module irq_and_error_status_flags_test;
  logic clk = 0, srst = 1, sli = 0, fp = 0, cca = 0, er;
  logic [16:0] ev = '0;
  logic [4:0] ctl = '0;
  logic [31:0] q;
  wire psel, penable, pwrite, pready, pslverr, mda, sef, ado;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  int miscompares = 0, n_tests = 0;
  logic [31:0] rows [18] = '{32'h0801_0020, 32'h0001_0000, 32'h0000_0108,
    32'h0100_0204, 32'h0000_0200, 32'h0000_0302, 32'h8000_0308,
    32'h0000_0401, 32'h8200_0509, 32'h8000_0508, 32'h0004_0601,
    32'h0000_0701, 32'h0002_0880, 32'h0000_0800, 32'h0010_0880,
    32'h0008_0910, 32'h0000_0900, 32'h0410_0001};
  iaes_host i_iaes_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  iaes_top i_iaes_top (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .secure_link_input(sli), .cmd_start(ev[11]),
    .auto_anticollision_command(ctl[4]), .authentication_command(ctl[2]),
    .crc_command_active(cca), .crc_all_processed(ev[16]),
    .rf_reset(ev[12]), .mode_identified(ev[13]), .field_present(fp),
    .mode_detector_active(mda), .rx_start(ev[14]),
    .active_comm_mode(ctl[0]), .host_fifo_write(ev[8]),
    .rf_exchange_window(ctl[1]), .fifo_write_attempt(ev[9]),
    .fifo_full(ctl[3]), .overheat_detect(ev[10]), .overheat_clear(ev[15]),
    .field_timeout_evt(ev[0]), .collision_evt(ev[1]),
    .crc_fail_evt(ev[2]), .parity_fail_evt(ev[3]), .sof_error_evt(ev[4]),
    .byte_length_evt(ev[5]), .auth_byte_count_evt(ev[6]),
    .miller_short_evt(ev[7]), .summary_error_flag(sef),
    .antenna_driver_off(ado));
  task automatic chk(input string n, input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    i_iaes_host.xfer(1'b0, a, 32'h0, q, er);
    chk("read data", q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_iaes_host.xfer(1'b1, a, d, q, er);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin
    cyc(20000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    cyc(12);
    srst <= 1'b0;
    rdc(8'h14, 32'h0);
    rdc(8'h18, 32'h0);
    wr(8'h18, 32'h0000_00ff);
    rdc(8'h18, 32'h0);
    rdc(8'h0c, 32'h0);
    chk("slave error", er, 1'b1);
    $display("reset and access test done");
    // Each row: config, control levels, event index, expected errors.
    foreach (rows[i]) begin
      wr(8'h40, rows[i][31:24]);
      @(posedge clk) ctl <= rows[i][20:16];
      pulse(11);
      pulse(rows[i][15:8]);
      rdc(8'h18, rows[i][7:0]);
      chk("summary", sef, |rows[i][7:0]);
      $display("row %0d done", i);
    end
    ctl <= '0;
    wr(8'h40, 32'h0);
    wr(8'h14, 32'h0000_00ff);
    rdc(8'h14, 32'h0000_001f);
    wr(8'h14, 32'h0000_0003);
    rdc(8'h14, 32'h0000_001c);
    wr(8'h14, 32'h0000_001c);
    rdc(8'h14, 32'h0);
    @(posedge clk) sli <= 1'b1;
    cyc(6);
    rdc(8'h14, 32'h0000_0010);
    wr(8'h14, 32'h0000_0010);
    sli <= 1'b0;
    fp <= 1'b1;
    cyc(6);
    rdc(8'h14, 32'h0000_0012);
    fp <= 1'b0;
    cca <= 1'b1;
    pulse(16);
    rdc(8'h14, 32'h0000_0017);
    pulse(13);
    rdc(8'h14, 32'h0000_001f);
    chk("detector", mda, 1'b0);
    pulse(11);
    cyc(2);
    chk("detector", mda, 1'b0);
    pulse(12);
    rdc(8'h14, 32'h0000_001f);
    chk("detector", mda, 1'b1);
    cca <= 1'b0;
    $display("flag test done");
    pulse(10);
    pulse(1);
    rdc(8'h18, 32'h0000_0048);
    chk("antenna off", ado, 1'b1);
    pulse(14);
    rdc(8'h18, 32'h0000_0040);
    pulse(11);
    rdc(8'h18, 32'h0000_0040);
    pulse(15);
    rdc(8'h18, 32'h0);
    chk("summary", sef, 1'b0);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    rdc(8'h14, 32'h0);
    $display("error and reset test done");
    tally_and_finish();
  end
endmodule
